// File: ofd_top.v
// Fast threshold detect, overrange sticky status and virtual converter mapping
// Assumes samples, overrange and register port are all synchronous to clk_sys_in
// Assumes a downconverter outside this block supplies decimated I and Q streams
`include "ofd_consts.vh"
`default_nettype none
module ofd_top #(
   // Sample word width; 16 puts the 13-bit magnitude in bits 12:0
   parameter SW = 16
) (
   input  wire          clk_sys_in,
   input  wire          nrst_in,
   input  wire          reg_wr_in,
   input  wire          reg_rd_in,
   input  wire [14:0]   reg_addr_in,
   input  wire [7:0]    reg_wdata_in,
   output reg  [7:0]    reg_rdata_out,
   input  wire [SW-1:0] adc_a_in,
   input  wire [SW-1:0] adc_b_in,
   input  wire          ovr_a_in,
   input  wire          ovr_b_in,
   input  wire [4*SW-1:0] ddc_i_in,
   input  wire [4*SW-1:0] ddc_q_in,
   input  wire          ddc_valid_in,
   input  wire [3:0]    link_cs_bits_in,
   output reg           threshold_flag_chan_a_out,
   output reg           threshold_flag_chan_b_out,
   output reg  [8*SW-1:0] vc_data_out,
   output reg  [7:0]    vc_ovr_out,
   output reg  [7:0]    vc_used_out,
   output reg           vc_valid_out,
   output reg  [3:0]    decim_ratio_out
);
   // Register images; thresholds keep all 16 written bits for readback,
   // but only bits 12:0 take part in the compares
   reg  [7:0]  mode_r;
   reg  [7:0]  decim_r;
   reg  [15:0] uth_r;
   reg  [15:0] lth_r;
   reg  [15:0] dwell_r;
   reg  [7:0]  clr_r;
   reg  [7:0]  clr_d_r;
   reg  [7:0]  ovr_stat_r;
   reg  [7:0]  ovr_stat_nxt;
   reg  [SW-1:0] a_d_r [0:`OFD_PIPE_LAT-1];
   reg  [SW-1:0] b_d_r [0:`OFD_PIPE_LAT-1];
   reg  [`OFD_PIPE_LAT-1:0] ova_d_r;
   reg  [`OFD_PIPE_LAT-1:0] ovb_d_r;
   // Dwell counters are one bit wider than the dwell value so they never wrap
   reg  [16:0] dw_a_r;
   reg  [16:0] dw_b_r;
   reg  [8*SW-1:0] vc_nxt;
   reg  [7:0]  vo_nxt;
   reg  [7:0]  vu_nxt;
   reg         vv_nxt;
   integer     k;

   // Absolute value, saturated to 13-bit magnitude scale
   // Two's complement minimum maps to full scale, not to zero
   // Saturation keeps large samples above any 13-bit threshold below full scale
   function [12:0] mag13;
      input [SW-1:0] s;
      reg   [SW-1:0] m;
      begin
         m = s[SW-1] ? (~s + {{(SW-1){1'b0}}, 1'b1}) : s;
         mag13 = (m[SW-1:SW-3] != 3'h0) ? 13'h1FFF : m[SW-4:0];
      end
   endfunction

   // Number of downconverter channels a mode code enables
   function [2:0] chan_count;
      input [3:0] md;
      begin
         case (md)
            `OFD_MODE_DDC1: chan_count = 3'h1;
            `OFD_MODE_DDC2: chan_count = 3'h2;
            `OFD_MODE_DDC4: chan_count = 3'h4;
            default:        chan_count = 3'h0;
         endcase
      end
   endfunction

   // Next {flag, dwell count} of one channel
   // Above upper sets the flag and restarts the count; this wins over expiry
   // At or above lower restarts the count while the flag is high
   // The flag falls once the count has reached the dwell value
   function [17:0] fd_step;
      input        flag;
      input [16:0] cnt;
      input [12:0] mag;
      input [12:0] upper;
      input [12:0] lower;
      input [15:0] dwell;
      begin
         if (mag > upper)
            fd_step = {1'b1, 17'h00000};
         else if (!flag)
            fd_step = {1'b0, cnt};
         else if (mag >= lower)
            fd_step = {1'b1, 17'h00000};
         else if (cnt >= {1'b0, dwell})
            fd_step = {1'b0, 17'h00000};
         else
            fd_step = {1'b1, cnt + 17'h00001};
      end
   endfunction

   // Magnitudes come straight from the sample inputs, so the set path is one register deep
   wire [12:0] mag_a = mag13(adc_a_in);
   wire [12:0] mag_b = mag13(adc_b_in);
   wire        qign  = mode_r[`OFD_QIGN_BIT];
   wire [3:0]  mode  = mode_r[`OFD_MODE_MSB:`OFD_MODE_LSB];
   // Overrange taps at the same depth as the sample taps
   wire        ova_al = ova_d_r[`OFD_PIPE_LAT-1];
   wire        ovb_al = ovb_d_r[`OFD_PIPE_LAT-1];
   wire        ovr_any = ova_al | ovb_al;
   wire [17:0] fd_a_nxt = fd_step(threshold_flag_chan_a_out, dw_a_r, mag_a, uth_r[12:0], lth_r[12:0], dwell_r);
   wire [17:0] fd_b_nxt = fd_step(threshold_flag_chan_b_out, dw_b_r, mag_b, uth_r[12:0], lth_r[12:0], dwell_r);

   // Register writes: one byte per strobe, exact address decode
   // Writes to the status byte and to unmapped addresses are dropped
   // Dwell low and high bytes are written separately; a dwell of zero
   // behaves like one below-threshold sample, which software must avoid

   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_r  <= `OFD_RST_BYTE;
         decim_r <= `OFD_RST_DECIM;
         uth_r   <= 16'h0000;
         lth_r   <= 16'h0000;
         dwell_r <= `OFD_RST_DWELL;
         clr_r   <= `OFD_RST_BYTE;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `OFD_ADDR_MODE:     mode_r  <= reg_wdata_in;
            `OFD_ADDR_DECIM:    decim_r <= reg_wdata_in;
            `OFD_ADDR_UTH_LO:   uth_r[7:0]  <= reg_wdata_in;
            `OFD_ADDR_UTH_HI:   uth_r[15:8] <= reg_wdata_in;
            `OFD_ADDR_LTH_LO:   lth_r[7:0]  <= reg_wdata_in;
            `OFD_ADDR_LTH_HI:   lth_r[15:8] <= reg_wdata_in;
            `OFD_ADDR_DWELL_LO: dwell_r[7:0]  <= reg_wdata_in;
            `OFD_ADDR_DWELL_HI: dwell_r[15:8] <= reg_wdata_in;
            `OFD_ADDR_OVR_CLR:  clr_r <= reg_wdata_in;
            default: ;
         endcase
      end
   end

   // Reads are registered and hold until the next read strobe
   // Unmapped addresses read as zero
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in)
         reg_rdata_out <= `OFD_RST_BYTE;
      else if (reg_rd_in) begin
         case (reg_addr_in)
            `OFD_ADDR_MODE:     reg_rdata_out <= mode_r;
            `OFD_ADDR_DECIM:    reg_rdata_out <= decim_r;
            `OFD_ADDR_UTH_LO:   reg_rdata_out <= uth_r[7:0];
            `OFD_ADDR_UTH_HI:   reg_rdata_out <= uth_r[15:8];
            `OFD_ADDR_LTH_LO:   reg_rdata_out <= lth_r[7:0];
            `OFD_ADDR_LTH_HI:   reg_rdata_out <= lth_r[15:8];
            `OFD_ADDR_DWELL_LO: reg_rdata_out <= dwell_r[7:0];
            `OFD_ADDR_DWELL_HI: reg_rdata_out <= dwell_r[15:8];
            `OFD_ADDR_OVR_CLR:  reg_rdata_out <= clr_r;
            `OFD_ADDR_OVR_STAT: reg_rdata_out <= ovr_stat_r;
            default:            reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // Flags: set in one cycle, clear after dwell below lower threshold
   // The count only advances while the flag is high and the magnitude
   // stays below lower; the flag falls after dwell plus one such samples
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         threshold_flag_chan_a_out <= 1'b0;
         threshold_flag_chan_b_out <= 1'b0;
         dw_a_r <= 17'h00000;
         dw_b_r <= 17'h00000;
      end else begin
         threshold_flag_chan_a_out <= fd_a_nxt[17];
         dw_a_r                    <= fd_a_nxt[16:0];
         threshold_flag_chan_b_out <= fd_b_nxt[17];
         dw_b_r                    <= fd_b_nxt[16:0];
      end
   end

   // Sample and overrange delay lines of equal length
   // A sample and its overrange bit leave the pipe in the same cycle
   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         for (k = 0; k < `OFD_PIPE_LAT; k = k + 1) begin
            a_d_r[k] <= {SW{1'b0}};
            b_d_r[k] <= {SW{1'b0}};
         end
         ova_d_r <= {`OFD_PIPE_LAT{1'b0}};
         ovb_d_r <= {`OFD_PIPE_LAT{1'b0}};
      end else begin
         a_d_r[0] <= adc_a_in;
         b_d_r[0] <= adc_b_in;
         for (k = 1; k < `OFD_PIPE_LAT; k = k + 1) begin
            a_d_r[k] <= a_d_r[k-1];
            b_d_r[k] <= b_d_r[k-1];
         end
         ova_d_r <= {ova_d_r[`OFD_PIPE_LAT-2:0], ovr_a_in};
         ovb_d_r <= {ovb_d_r[`OFD_PIPE_LAT-2:0], ovr_b_in};
      end
   end

   // Virtual converter mapping
   // Full bandwidth runs every cycle; downconverter modes follow the
   // downconverter strobe. Unused lanes carry zero samples and no
   // overrange, and an undefined mode code turns every lane off.
   // In downconverter modes each lane in use reports the overrange of both inputs while link_cs_bits_in is nonzero
   always @* begin
      vc_nxt = {8*SW{1'b0}};
      vo_nxt = 8'h00;
      vu_nxt = 8'h00;
      vv_nxt = ddc_valid_in;
      case (mode)
         `OFD_MODE_FULL: begin
            vc_nxt[SW-1:0]    = a_d_r[`OFD_PIPE_LAT-1];
            vc_nxt[2*SW-1:SW] = b_d_r[`OFD_PIPE_LAT-1];
            vo_nxt[1:0] = {ovb_al, ova_al};
            vu_nxt = 8'h03;
            vv_nxt = 1'b1;
         end
         `OFD_MODE_DDC1, `OFD_MODE_DDC2, `OFD_MODE_DDC4: begin
            for (k = 0; k < 4; k = k + 1) begin
               if (k < chan_count(mode)) begin
                  // Real output packs the I streams on consecutive lanes
                  if (qign) begin
                     vc_nxt[k*SW +: SW] = ddc_i_in[k*SW +: SW];
                     vu_nxt[k] = 1'b1;
                     vo_nxt[k] = ovr_any;
                  end else begin
                     // I on the even lane, Q on the odd lane above it
                     vc_nxt[2*k*SW +: SW]     = ddc_i_in[k*SW +: SW];
                     vc_nxt[(2*k+1)*SW +: SW] = ddc_q_in[k*SW +: SW];
                     vu_nxt[2*k]   = 1'b1;
                     vu_nxt[2*k+1] = 1'b1;
                     vo_nxt[2*k]   = ovr_any;
                     vo_nxt[2*k+1] = ovr_any;
                  end
               end
            end
         end
         default: vv_nxt = 1'b0;
      endcase
      if (link_cs_bits_in == 4'h0)
         vo_nxt = 8'h00;
   end

   // Sticky status: clear on the falling edge of a clear bit, then set,
   // so an overrange in the clearing cycle is not lost
   // Only lanes in use can set a bit
   always @* begin
      ovr_stat_nxt = ovr_stat_r & ~(clr_d_r & ~clr_r);
      ovr_stat_nxt = ovr_stat_nxt | (vo_nxt & vu_nxt);
   end

   always @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         // All outputs are registered; mapping adds one cycle after the taps
         vc_data_out     <= {8*SW{1'b0}};
         vc_ovr_out      <= 8'h00;
         vc_used_out     <= 8'h00;
         vc_valid_out    <= 1'b0;
         decim_ratio_out <= 4'h0;
         clr_d_r         <= 8'h00;
         ovr_stat_r      <= 8'h00;
      end else begin
         vc_data_out     <= vc_nxt;
         vc_ovr_out      <= vo_nxt;
         vc_used_out     <= vu_nxt;
         vc_valid_out    <= vv_nxt;
         decim_ratio_out <= decim_r[3:0];
         clr_d_r         <= clr_r;
         ovr_stat_r      <= ovr_stat_nxt;
      end
   end
endmodule // ofd_top
`default_nettype wire

// File: ofd_consts.vh
// Register offsets, field positions, reset values and timing counts for the fast detect block
// Assumes a simple byte-wide register port driven by an external serial control decoder
`ifndef OFD_CONSTS_VH
`define OFD_CONSTS_VH
`define OFD_ADDR_MODE        15'h0200
`define OFD_ADDR_DECIM       15'h0201
`define OFD_ADDR_UTH_LO      15'h0247
`define OFD_ADDR_UTH_HI      15'h0248
`define OFD_ADDR_LTH_LO      15'h0249
`define OFD_ADDR_LTH_HI      15'h024A
`define OFD_ADDR_DWELL_LO    15'h024B
`define OFD_ADDR_DWELL_HI    15'h024C
`define OFD_ADDR_OVR_CLR     15'h0562
`define OFD_ADDR_OVR_STAT    15'h0563
`define OFD_MODE_LSB         0
`define OFD_MODE_MSB         3
`define OFD_QIGN_BIT         5
`define OFD_MODE_FULL        4'h0
`define OFD_MODE_DDC1        4'h1
`define OFD_MODE_DDC2        4'h2
`define OFD_MODE_DDC4        4'h3
`define OFD_RST_BYTE         8'h00
`define OFD_RST_DECIM        8'h01
`define OFD_RST_DWELL        16'h0001
`define OFD_UPPER_LAT_MAX    28
`define OFD_PIPE_LAT         2
`endif

// File: ofd_top_assertions.sv
// Port checker for ofd_top: register side effects, flag set, lane map, overrange alignment
// Assumes registers change only through the byte port of ofd_top
`include "ofd_consts.vh"
`default_nettype none
module ofd_chk #(parameter SW = 16) (
   input wire logic clk_sys_in,
   input wire logic nrst_in,
   input wire logic reg_wr_in,
   input wire logic reg_rd_in,
   input wire logic [14:0] reg_addr_in,
   input wire logic [7:0] reg_wdata_in,
   input wire logic [7:0] reg_rdata_out,
   input wire logic [SW-1:0] adc_a_in,
   input wire logic [SW-1:0] adc_b_in,
   input wire logic ovr_a_in,
   input wire logic ovr_b_in,
   input wire logic [4*SW-1:0] ddc_i_in,
   input wire logic [4*SW-1:0] ddc_q_in,
   input wire logic ddc_valid_in,
   input wire logic [3:0] link_cs_bits_in,
   input wire logic threshold_flag_chan_a_out,
   input wire logic threshold_flag_chan_b_out,
   input wire logic [8*SW-1:0] vc_data_out,
   input wire logic [7:0] vc_ovr_out,
   input wire logic [7:0] vc_used_out,
   input wire logic vc_valid_out,
   input wire logic [3:0] decim_ratio_out
);
   timeunit 1ns; timeprecision 1ps;
   logic [7:0] mode_r;
   logic [12:0] uth_r;
   logic [2:0] cnt_r;
   // Settle count since reset or mode write, so the map is judged only when steady
   always_ff @(posedge clk_sys_in or negedge nrst_in) begin
      if (!nrst_in) begin
         mode_r <= 8'h00;
         uth_r <= 13'h0000;
         cnt_r <= 3'h0;
      end else begin
         cnt_r <= (reg_wr_in && reg_addr_in == `OFD_ADDR_MODE) ? 3'h0 : cnt_r + 3'(cnt_r != 3'h4);
         if (reg_wr_in && reg_addr_in == `OFD_ADDR_MODE) mode_r <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `OFD_ADDR_UTH_LO) uth_r[7:0] <= reg_wdata_in;
         if (reg_wr_in && reg_addr_in == `OFD_ADDR_UTH_HI) uth_r[12:8] <= reg_wdata_in[4:0];
      end
   end
   function automatic logic [12:0] mag(input logic [SW-1:0] s);
      logic [SW:0] a;
      a = s[SW-1] ? -{s[SW-1], s} : {1'b0, s};
      return (a > 13'h1FFF) ? 13'h1FFF : a[12:0];
   endfunction
   wire logic ok = cnt_r == 3'h4;
   default clocking @(posedge clk_sys_in); endclocking
   default disable iff (!nrst_in);
   sequence s_dec_wr; reg_wr_in && reg_addr_in == `OFD_ADDR_DECIM ##2 1'b1; endsequence
   property p_dec; s_dec_wr |-> {4'h0, decim_ratio_out} == ($past(reg_wdata_in, 2) & 8'h0F); endproperty
   a_dec: assert property (p_dec) else $error("decimation ratio wrong");
   property p_set_a; mag(adc_a_in) > uth_r |=> threshold_flag_chan_a_out; endproperty
   a_set_a: assert property (p_set_a) else $error("flag a not set");
   property p_set_b; mag(adc_b_in) > uth_r |=> threshold_flag_chan_b_out; endproperty
   a_set_b: assert property (p_set_b) else $error("flag b not set");
   property p_full; ok && mode_r == 8'h00 |-> vc_used_out == 8'h03 && vc_valid_out; endproperty
   a_full: assert property (p_full) else $error("full band lanes wrong");
   property p_c4; ok && mode_r == 8'h03 |-> vc_used_out == 8'hFF; endproperty
   a_c4: assert property (p_c4) else $error("four complex lanes wrong");
   property p_bad; ok && mode_r[3:0] > 4'h3 |-> vc_used_out == 8'h00 && !vc_valid_out; endproperty
   a_bad: assert property (p_bad) else $error("bad mode not idle");
   property p_data; ok && mode_r == 8'h00 |-> vc_data_out[2*SW-1:0] == {$past(adc_b_in, 3), $past(adc_a_in, 3)}; endproperty
   a_data: assert property (p_data) else $error("lane samples wrong");
   property p_ovr; ok && mode_r == 8'h00 && vc_ovr_out[0] |-> $past(ovr_a_in, 3); endproperty
   a_ovr: assert property (p_ovr) else $error("overrange misaligned");
endmodule // ofd_chk
bind ofd_top ofd_chk #(.SW(SW)) ofd_chk_inst (.*);
`default_nettype wire

// File: ofd_agc_model.sv
// Gain control stand-in: one gain step per new flag assertion
// Assumes the flag is synchronous to the sample clock
`default_nettype none
module ofd_agc_model (
   input wire logic clk_sys_in,
   input wire logic flag_in,
   output var logic [7:0] steps_out
);
   timeunit 1ns; timeprecision 1ps;
   logic prev_r = 1'b0;
   initial steps_out = 8'h00;
   always @(posedge clk_sys_in) begin
      prev_r <= flag_in;
      if (flag_in && !prev_r) steps_out <= steps_out + 8'h01;
   end
endmodule // ofd_agc_model
`default_nettype wire

// File: ofd_top_tb_top.sv
// Bench for ofd_top: registers, fast detect, lane map, sticky overrange
// Assumes the checker is bound to ofd_top and the gain model watches flag a
`include "ofd_consts.vh"
`default_nettype none
module ofd_top_tb_top;
   timeunit 1ns; timeprecision 1ps;
   logic clk_sys_in = 1'b0, nrst_in = 1'b0, reg_wr_in = 1'b0, reg_rd_in = 1'b0;
   logic ovr_a_in = 1'b0, ovr_b_in = 1'b0, ddc_valid_in = 1'b0, vc_valid_out;
   logic threshold_flag_chan_a_out, threshold_flag_chan_b_out;
   logic [14:0] reg_addr_in = 15'h0000;
   logic [7:0] reg_wdata_in = 8'h00, reg_rdata_out, vc_ovr_out, vc_used_out, steps;
   logic [15:0] adc_a_in = 16'h0000, adc_b_in = 16'h0000;
   logic [63:0] ddc_i_in = 64'h0, ddc_q_in = 64'h0;
   logic [3:0] link_cs_bits_in = 4'h1, decim_ratio_out;
   logic [127:0] vc_data_out;
   logic [31:0] lfsr = 32'h3C6D;
   int num_errors = 0, cmp_count = 0, cyc = 0;
   ofd_top #(.SW(16)) ofd_top_inst (.*);
   ofd_agc_model ofd_agc_model_inst (.clk_sys_in(clk_sys_in), .flag_in(threshold_flag_chan_a_out), .steps_out(steps));
   initial forever #4 clk_sys_in = ~clk_sys_in;
   function automatic logic [31:0] rnd();
      lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
      return lfsr;
   endfunction
   function automatic logic [7:0] exp_used(input logic [7:0] m);
      logic [3:0] n;
      n = (m[3:0] == 4'h3) ? 4'h4 : m[3:0];
      if (m[3:0] > 4'h3) return 8'h00;
      if (m[3:0] == 4'h0) return 8'h03;
      return 8'((16'h1 << (m[5] ? n : 2 * n)) - 16'h1);
   endfunction
   task automatic cmp(input logic [127:0] got, input logic [127:0] exp);
      cmp_count++;
      if (got !== exp) begin
         num_errors++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [14:0] a, input logic [7:0] d);
      @(negedge clk_sys_in);
      reg_wr_in = 1'b1;
      reg_addr_in = a;
      reg_wdata_in = d;
      @(negedge clk_sys_in);
      reg_wr_in = 1'b0;
   endtask
   task automatic rd(input logic [14:0] a, input logic [7:0] e);
      @(negedge clk_sys_in);
      reg_rd_in = 1'b1;
      reg_addr_in = a;
      @(negedge clk_sys_in);
      reg_rd_in = 1'b0;
      cmp(128'(reg_rdata_out), 128'(e));
   endtask
   task automatic close_out();
      $display("compares %0d mismatches %0d", cmp_count, num_errors);
      if (num_errors == 0 && cmp_count > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   always @(posedge clk_sys_in) begin
      cyc++;
      if (cyc == 5000) begin
         num_errors++;
         close_out();
      end
   end
   initial begin
      logic [7:0] modes [8];
      logic [15:0] fv [8];
      modes = '{8'h00, 8'h01, 8'h21, 8'h02, 8'h22, 8'h03, 8'h23, 8'h05};
      fv = '{16'h012C, 16'h0032, 16'h0032, 16'h0096, 16'h0032, 16'h0032, 16'h0032, 16'h0032};
      repeat (4) @(posedge clk_sys_in);
      @(negedge clk_sys_in) nrst_in = 1'b1;
      rd(`OFD_ADDR_MODE, 8'h00);
      rd(`OFD_ADDR_DWELL_LO, 8'h01);
      rd(15'h7FFF, 8'h00);
      wr(`OFD_ADDR_DECIM, 8'hF4);
      @(negedge clk_sys_in);
      cmp(128'(decim_ratio_out), 128'(4'h4));
      rd(`OFD_ADDR_DECIM, 8'hF4);
      $display("test registers done");
      wr(`OFD_ADDR_UTH_LO, 8'hC8);
      wr(`OFD_ADDR_LTH_LO, 8'h64);
      wr(`OFD_ADDR_DWELL_LO, 8'h02);
      for (int i = 0; i < 9; i++) begin
         @(negedge clk_sys_in);
         if (i > 0) cmp(128'({threshold_flag_chan_a_out, threshold_flag_chan_b_out}), 128'({2{i < 7}}));
         adc_a_in = (i < 8) ? fv[i] : 16'h0000;
         adc_b_in = -adc_a_in;
      end
      cmp(128'(steps), 128'(8'h01));
      $display("test fast detect done");
      ddc_valid_in = 1'b1;
      for (int m = 0; m < 8; m++) begin
         ddc_i_in = {rnd(), rnd()};
         ddc_q_in = {rnd(), rnd()};
         wr(`OFD_ADDR_MODE, modes[m]);
         repeat (4) @(negedge clk_sys_in);
         cmp(128'({vc_valid_out, vc_used_out}), 128'({modes[m][3:0] < 4'h4, exp_used(modes[m])}));
         for (int k = 0; k < 4; k++)
            if (modes[m] == 8'h03) cmp(128'(vc_data_out[32*k +: 32]), 128'({ddc_q_in[16*k +: 16], ddc_i_in[16*k +: 16]}));
         if (modes[m] == 8'h23) cmp(128'(vc_data_out[63:0]), 128'(ddc_i_in));
      end
      $display("test lane map done");
      wr(`OFD_ADDR_MODE, 8'h00);
      for (int i = 0; i < 300; i++) begin
         @(negedge clk_sys_in);
         {adc_a_in, adc_b_in} = rnd();
         ovr_a_in = i == 100;
         ovr_b_in = i == 200;
      end
      rd(`OFD_ADDR_OVR_STAT, 8'h03);
      wr(`OFD_ADDR_OVR_CLR, 8'h01);
      wr(`OFD_ADDR_OVR_CLR, 8'h00);
      rd(`OFD_ADDR_OVR_STAT, 8'h02);
      link_cs_bits_in = 4'h0;
      ovr_a_in = 1'b1;
      @(negedge clk_sys_in);
      ovr_a_in = 1'b0;
      repeat (5) @(negedge clk_sys_in);
      rd(`OFD_ADDR_OVR_STAT, 8'h02);
      $display("test overrange done");
      close_out();
   end
endmodule // ofd_top_tb_top
`default_nettype wire
